/* logic/seeb_front_end.sv */
/*
  two-wire target front end of a serial eeprom, with its array, write
  protection, self-timed write busy window and standby indication.
  assumes the serial clock is made by the controller and may stop between
  frames; the data pin is resolved outside from sda_o and sda_oe_o.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seeb_regs.svh"

module seeb_front_end #(
  parameter int VARIANT_KBIT = `SEEB_VARIANT_KBIT,
  parameter int TWR_CYCLES   = `SEEB_TWR_CYC
) (
  // system clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // two-wire link
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe_o,
  // straps and protection
  input  wire logic select_pin_upper_i,
  input  wire logic select_pin_middle_i,
  input  wire logic select_pin_lower_i,
  input  wire logic write_protect_i,
  // status
  output var  logic standby_o,
  output var  logic busy_o
);

  // ****************************************************************
  // geometry of the chosen variant
  // ****************************************************************
  localparam int DEPTH = VARIANT_KBIT * `SEEB_BYTES_PER_KBIT;
  localparam int AW    = $clog2(DEPTH);
  localparam int NPAGE = AW - 8;
  localparam int PB    = (VARIANT_KBIT == 2) ?
                         `SEEB_PAGE_BITS_SMALL : `SEEB_PAGE_BITS_LARGE;
  localparam int TW    = $clog2(TWR_CYCLES + 1);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [5:0]              meta_q;
  logic [5:0]              sync_q;
  logic                    scl_prev_q;
  logic                    sda_prev_q;
  logic                    scl_s;
  logic                    sda_s;
  logic [2:0]              pins_s;
  logic                    wp_s;
  logic                    scl_rise;
  logic                    start_det;
  logic                    stop_det;
  seeb_pkg::seeb_state_e   state_q;
  logic [3:0]              bit_cnt_q;
  logic [7:0]              rx_q;
  logic [7:0]              rx_byte;
  logic [7:0]              tx_q;
  logic                    drive_q;
  logic [AW-1:0]           addr_q;
  logic [AW-1:0]           addr_seq;
  logic [AW-1:0]           addr_page;
  logic [AW-1:0]           addr_word;
  logic [10:0]             addr_full;
  logic [2:0]              page_q;
  logic                    wr_pend_q;
  logic [2:0]              sel_ok;
  logic                    dev_match;
  logic                    word_done;
  logic                    mem_we;
  logic [7:0]              mem_rd;
  logic [7:0]              mem_q [DEPTH];
  logic [TW-1:0]           busy_cnt_q;
  logic                    busy_q;
  logic                    standby_q;
  logic                    sda_oe_q;
  logic                    sda_o_q;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // clock and data pass the same two stages so their skew stays equal
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= `SEEB_SYNC_RST;
      sync_q <= `SEEB_SYNC_RST;
    end else begin
      meta_q <= {write_protect_i, select_pin_upper_i, select_pin_middle_i,
                 select_pin_lower_i, sda_i, scl_i};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= sync_q[0];
      sda_prev_q <= sync_q[1];
    end
  end

  assign scl_s  = sync_q[0];
  assign sda_s  = sync_q[1];
  assign pins_s = sync_q[4:2];
  assign wp_s   = sync_q[5];

  // ****************************************************************
  // bus conditions
  // ****************************************************************
  assign scl_rise  = scl_s & ~scl_prev_q;                            // R2
  // data moving under a high clock is never data
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;        // R8 R9
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;        // R8 R10

  assign rx_byte   = {rx_q[6:0], sda_s};                              // R11
  assign word_done = scl_rise && (bit_cnt_q == `SEEB_BIT_LAST);

  // ****************************************************************
  // device address compare
  // ****************************************************************
  // select bits below NPAGE are page bits and skip the pin compare
  for (genvar i = 0; i < 3; i++) begin : g_sel
    assign sel_ok[i] = (i < NPAGE) || (rx_byte[i+1] == pins_s[i]);  // R16 R17 R18 R19
  end

  // busy hides the device so the controller can poll for completion
  assign dev_match = (rx_byte[7:4] == `SEEB_TYPE_PATTERN)            // R15 R25
                   && (&sel_ok)
                   && !busy_q;                                       // R24

  // ****************************************************************
  // address arithmetic
  // ****************************************************************
  assign addr_full = {page_q, rx_byte};                               // R20
  assign addr_word = addr_full[AW-1:0];                               // R4 R5 R6 R7
  // reads roll over the whole array
  assign addr_seq  = addr_q + 1'b1;
  // writes roll over within the current page
  assign addr_page = {addr_q[AW-1:PB], addr_q[PB-1:0] + 1'b1};        // R4 R5 R6 R7

  // ****************************************************************
  // array
  // ****************************************************************
  assign mem_rd = mem_q[addr_q];
  assign mem_we = word_done && (state_q == seeb_pkg::SEEB_WDATA)
                && !wp_s;                                            // R3

  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem_q[addr_q] <= rx_byte;
    end
  end

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  // drive_q is the pull-low enable wanted on the data line for the next bit slot;
  // it is settled a few system cycles after a clock rise and is taken by
  // the link side on the following fall
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q   <= seeb_pkg::SEEB_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q      <= 8'h00;
      tx_q      <= 8'h00;
      drive_q   <= 1'b0;
      addr_q    <= '0;
      page_q    <= 3'h0;
      wr_pend_q <= 1'b0;
    end else if (start_det) begin
      // abandon whatever was under way, even mid-word
      state_q   <= seeb_pkg::SEEB_ADDR;                               // R9 R14 R26
      bit_cnt_q <= 4'h0;
      drive_q   <= 1'b0;
    end else if (stop_det) begin
      state_q   <= seeb_pkg::SEEB_IDLE;                               // R10 R12
      bit_cnt_q <= 4'h0;
      drive_q   <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (scl_rise && state_q != seeb_pkg::SEEB_IDLE
                 && state_q != seeb_pkg::SEEB_SKIP) begin
      if (bit_cnt_q == `SEEB_BIT_ACK) begin
        bit_cnt_q <= 4'h0;
        unique case (state_q)
          seeb_pkg::SEEB_RACK: begin
            drive_q <= ~tx_q[7];
            state_q <= seeb_pkg::SEEB_RDATA;
          end
          seeb_pkg::SEEB_RDATA: begin
            if (sda_s) begin
              // no acknowledge from the controller: wait for its stop
              drive_q <= 1'b0;
              state_q <= seeb_pkg::SEEB_SKIP;
            end else begin
              tx_q    <= mem_rd;
              drive_q <= ~mem_rd[7];
              addr_q  <= addr_seq;
            end
          end
          seeb_pkg::SEEB_IDLE, seeb_pkg::SEEB_ADDR, seeb_pkg::SEEB_WORD,
          seeb_pkg::SEEB_WDATA, seeb_pkg::SEEB_SKIP: begin
            drive_q <= 1'b0;
          end
        endcase
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        rx_q      <= rx_byte;
        if (state_q == seeb_pkg::SEEB_RDATA) begin
          tx_q    <= {tx_q[6:0], 1'b0};
          drive_q <= (bit_cnt_q == `SEEB_BIT_LAST) ? 1'b0 : ~tx_q[6];
        end else begin
          drive_q <= 1'b0;
        end
        if (bit_cnt_q == `SEEB_BIT_LAST) begin
          unique case (state_q)
            seeb_pkg::SEEB_ADDR: begin
              if (dev_match) begin
                drive_q <= 1'b1;                                      // R11 R22
                page_q  <= rx_byte[3:1];                              // R17 R18 R19
                if (rx_byte[0]) begin                                 // R21
                  state_q <= seeb_pkg::SEEB_RACK;
                  tx_q    <= mem_rd;
                  addr_q  <= addr_seq;
                end else begin
                  state_q <= seeb_pkg::SEEB_WORD;
                end
              end else begin
                state_q <= seeb_pkg::SEEB_SKIP;                       // R22
              end
            end
            seeb_pkg::SEEB_WORD: begin
              addr_q  <= addr_word;                                   // R20 R23
              drive_q <= 1'b1;                                        // R23
              state_q <= seeb_pkg::SEEB_WDATA;
            end
            seeb_pkg::SEEB_WDATA: begin
              drive_q <= 1'b1;                                        // R11
              addr_q  <= addr_page;
              if (!wp_s) begin
                wr_pend_q <= 1'b1;                                    // R3
              end
            end
            seeb_pkg::SEEB_IDLE, seeb_pkg::SEEB_RACK,
            seeb_pkg::SEEB_RDATA, seeb_pkg::SEEB_SKIP: begin
              // the controller acknowledges data words itself
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // self-timed write window
  // ****************************************************************
  // the array is written as bytes arrive; the window only models the
  // time during which the part stays deaf after the closing stop
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_q <= '0;
      busy_q     <= 1'b0;
    end else if (stop_det && wr_pend_q) begin
      busy_cnt_q <= TW'(TWR_CYCLES - 1);                              // R24
      busy_q     <= 1'b1;
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - 1'b1;
    end else begin
      busy_q     <= 1'b0;
    end
  end

  // ****************************************************************
  // status
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      standby_q <= 1'b1;                                              // R12
    end else begin
      standby_q <= (state_q == seeb_pkg::SEEB_IDLE) && !busy_q;        // R10 R12
    end
  end

  assign standby_o = standby_q;
  assign busy_o    = busy_q;

  // ****************************************************************
  // link side output stage
  // ****************************************************************
  // runs on the falling serial clock, so the line only moves while the
  // clock is low; drive_q has been stable since a few system cycles after the preceding rise, and
  // the bus protocol keeps that window far longer than the settle time
  always_ff @(negedge scl_i or posedge reset_i) begin
    if (reset_i) begin
      sda_oe_q <= 1'b0;
      sda_o_q  <= 1'b0;
    end else begin
      sda_oe_q <= drive_q;                                            // R2 R8
      sda_o_q  <= 1'b0;                                               // R1
    end
  end

  assign sda_oe_o = sda_oe_q;
  assign sda_o    = sda_o_q;

endmodule : seeb_front_end

`default_nettype wire

/* shared/seeb_pkg.sv */
/*
  types for the serial eeprom bus front end.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package seeb_pkg;

  // ****************************************************************
  // transfer phase
  // ****************************************************************
  typedef enum logic [2:0] {
    SEEB_IDLE  = 3'b000,
    SEEB_ADDR  = 3'b001,
    SEEB_WORD  = 3'b010,
    SEEB_WDATA = 3'b011,
    SEEB_RACK  = 3'b100,
    SEEB_RDATA = 3'b101,
    SEEB_SKIP  = 3'b110
  } seeb_state_e;

endpackage : seeb_pkg

`default_nettype wire

/* shared/seeb_regs.svh */
/*
  constants for the serial eeprom bus front end: type pattern, write timing,
  variant defaults and word framing.
  assumes a 200 MHz system clock; included by its bare name.
*/
`ifndef SEEB_REGS_SVH
`define SEEB_REGS_SVH

// Summary of operation
// [R1] data line is only pulled low or released, never driven high
// [R2] bits taken on serial clock rise, output bits change on its fall
// [R3] write-protect high blocks every array write; low allows normal access
// [R4] 2K variant: 32 pages of 8 bytes, 8-bit word address
// [R5] 4K variant: 32 pages of 16 bytes, 9-bit word address
// [R6] 8K variant: 64 pages of 16 bytes, 10-bit word address
// [R7] 16K variant: 128 pages of 16 bytes, 11-bit word address
// [R8] data changes only with clock low; changes with clock high are start/stop
// [R9] data falling while clock high is a start; one precedes every command
// [R10] data rising while clock high is a stop; stop after read enters standby
// [R11] words are 8 bits; device pulls data low in the ninth clock
// [R12] standby at power-up and after stop once internal work is finished
// [R13] controller recovers the bus with up to 9 clocks then a start
// [R14] every transfer opens with a device address word right after start
// [R15] upper four address bits must equal the fixed type pattern
// [R16] 2K variant compares all three select bits with their pins
// [R17] 4K variant compares two upper select bits; lowest is a page bit
// [R18] 8K variant compares upper select bit; next two are page bits
// [R19] 16K variant compares no select pins; three page bits
// [R20] page bits sit above the following word address byte
// [R21] last address bit picks read when 1, write when 0
// [R22] match acknowledges with 0; mismatch releases the line and idles; code waits in SEEB_SKIP, standby low, until a stop or start
// [R23] a write sends a word address byte, which is acknowledged
// [R24] no address acknowledge while the self-timed write runs
// [R25] type pattern is binary 1010
// [R26] a start anywhere abandons the transfer and awaits a new address

// ****************************************************************
// word framing and addressing
// ****************************************************************
`define SEEB_TYPE_PATTERN    4'ha
`define SEEB_BIT_LAST        4'h7
`define SEEB_BIT_ACK         4'h8
`define SEEB_VARIANT_KBIT    2
`define SEEB_PAGE_BITS_SMALL 3
`define SEEB_PAGE_BITS_LARGE 4
`define SEEB_BYTES_PER_KBIT  128

// ****************************************************************
// timing
// ****************************************************************
`define SEEB_CLK_PERIOD_NS   5
`define SEEB_TWR_NS          5000000
// longest time, so rounded down
`define SEEB_TWR_CYC         (`SEEB_TWR_NS / `SEEB_CLK_PERIOD_NS)

// ****************************************************************
// synchroniser reset image: clock and data idle high, straps low
// ****************************************************************
`define SEEB_SYNC_RST        6'h03

`endif

/* sim/seeb_ctl_model.sv */
/*
  behavioural two-wire bus controller with a 48 ns serial clock.
  assumes an outside pull-up resolves the data line into sda_i.
*/
`timescale 1ns/1ps
`default_nettype none

module seeb_ctl_model (
  // clock and data pull-down
  output var  logic scl_o,
  output var  logic pull_o,
  // resolved data line
  input  wire logic sda_i
);
  // ********
  // clock stands high between frames
  // ********
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  task automatic bit_io(input logic b, output logic s);
    #16 pull_o = !b;
    #8 scl_o = 1'b1;
    s = sda_i;
    #24 scl_o = 1'b0;
  endtask : bit_io

  task automatic recover();
    logic s;
    repeat (9) bit_io(1'b1, s);
  endtask : recover

  task automatic start();
    if (!scl_o) begin
      #16 pull_o = 1'b0;
      #8 scl_o = 1'b1;
      #24;
    end
    pull_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask : start

  task automatic stop();
    #16 pull_o = 1'b1;
    #8 scl_o = 1'b1;
    #24 pull_o = 1'b0;
    #24;
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], ack);
    bit_io(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, s);
      d = {d[6:0], s};
    end
    bit_io(last, s);
  endtask : rbyte
endmodule : seeb_ctl_model

`default_nettype wire

/* sim/seeb_front_end_assertions.sv */
/*
  port checker for the eeprom bus front end.
  assumes it is bound onto the front end and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module seeb_front_end_assertions #(
  parameter int VARIANT_KBIT = 2,
  parameter int TWR_CYCLES   = 20
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // link
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // straps and status
  input wire logic select_pin_upper_i,
  input wire logic select_pin_middle_i,
  input wire logic select_pin_lower_i,
  input wire logic write_protect_i,
  input wire logic standby_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // ********
  // busy window length, counted here since it is far beyond a repetition
  // ********
  int busy_cnt_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_o ? busy_cnt_q + 1 : 0;
  end

  property p_open_drain; sda_oe_o |-> sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_out_on_fall; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data moved, clock high");
  property p_idle_released; standby_o |-> !sda_oe_o; endproperty
  a_idle_released: assert property (p_idle_released) else $error("idle but driving");
  property p_busy_no_ack; busy_o |-> !sda_oe_o; endproperty
  a_busy_no_ack: assert property (p_busy_no_ack) else $error("answered while busy");
  property p_busy_not_idle; busy_o |-> !standby_o; endproperty
  a_busy_not_idle: assert property (p_busy_not_idle) else $error("standby while busy");
  property p_busy_len;
    $fell(busy_o) |-> busy_cnt_q inside {[TWR_CYCLES - 1:TWR_CYCLES + 1]};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy window length");
  property p_idle_after; $fell(busy_o) |-> ##[0:2] standby_o; endproperty
  a_idle_after: assert property (p_idle_after) else $error("no standby after write");
  property p_busy_cause; $rose(busy_o) |-> scl_i && sda_i && !write_protect_i; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without stop");
  property p_start_restart; scl_i && $fell(sda_i) |=> !sda_oe_o [*8]; endproperty
  a_start_restart: assert property (p_start_restart) else $error("drive after start");

  c_busy: cover property ($rose(busy_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_start: cover property (scl_i && $fell(sda_i));
endmodule : seeb_front_end_assertions

bind seeb_front_end seeb_front_end_assertions #(
  .VARIANT_KBIT(VARIANT_KBIT),
  .TWR_CYCLES  (TWR_CYCLES)
) u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_pin_upper_i(select_pin_upper_i),
  .select_pin_middle_i(select_pin_middle_i), .select_pin_lower_i(select_pin_lower_i),
  .write_protect_i(write_protect_i), .standby_o(standby_o), .busy_o(busy_o)
);

`default_nettype wire

/* sim/seeb_front_end_tb.sv */
/*
  self-checking bench for the eeprom bus front end, 2K variant.
  assumes the controller model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module seeb_front_end_tb;
  logic        clk_sys_i, reset_i, scl, pull, sda, sda_o, oe, stby, busy, wp;
  logic [2:0]  sel;
  logic [31:0] seed;
  logic [7:0]  mem [256];
  int          err_count, samples_checked, cyc;

  // ********
  // wired line with pull-up
  // ********
  assign sda = !(pull || oe);
  seeb_ctl_model m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  seeb_front_end #(.VARIANT_KBIT(2), .TWR_CYCLES(200)) uut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(oe), .select_pin_upper_i(sel[2]),
    .select_pin_middle_i(sel[1]), .select_pin_lower_i(sel[0]),
    .write_protect_i(wp), .standby_o(stby), .busy_o(busy)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic close_out();
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t bit %b exp %b", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t byte %h exp %h", $time, g, e);
    end
  endtask : chk_byte

  task automatic dev(input logic rd, output logic a);
    m.start();
    m.wbyte({4'ha, sel, rd}, a);
  endtask : dev

  task automatic wr(input logic [7:0] ad, input int n, input logic [7:0] d0);
    logic a;
    dev(1'b0, a);
    chk_bit(a, 1'b0);
    m.wbyte(ad, a);
    chk_bit(a, 1'b0);
    for (int j = 0; j < n; j++) begin
      m.wbyte(d0 + 8'(j), a);
      chk_bit(a, 1'b0);
      if (!wp) mem[{ad[7:3], ad[2:0] + 3'(j)}] = d0 + 8'(j);
    end
    m.stop();
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk_bit(busy, !wp);
    if (!wp) begin
      dev(1'b0, a);
      m.stop();
      chk_bit(a, 1'b1);
      for (int t = 0; t < 400 && busy !== 1'b0; t++) @(posedge clk_sys_i);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk_bit(stby, 1'b1);
    end
  endtask : wr

  // random read: dummy write, repeated start, then a sequential run
  task automatic rd(input logic [7:0] ad, input int n);
    logic       a;
    logic [7:0] q;
    dev(1'b0, a);
    m.wbyte(ad, a);
    dev(1'b1, a);
    chk_bit(a, 1'b0);
    for (int j = 0; j < n; j++) begin
      m.rbyte(j == n - 1, q);
      chk_byte(q, mem[ad + 8'(j)]);
    end
    m.stop();
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk_bit(stby, 1'b1);
  endtask : rd

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = !clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    logic a;
    reset_i = 1'b1;
    wp = 1'b0;
    sel = 3'h0;
    seed = 32'h057d0998;
    repeat (3) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    sel = seed[2:0];
    chk_bit(stby, 1'b1);
    m.recover();
    for (int i = 0; i < 16; i++) begin
      if (i != 10) begin
        m.start();
        m.wbyte({4'(i), sel, 1'b0}, a);
        m.stop();
        chk_bit(a, 1'b1);
      end
    end
    for (int i = 1; i < 8; i++) begin
      m.start();
      m.wbyte({4'ha, sel ^ 3'(i), 1'b1}, a);
      m.stop();
      chk_bit(a, 1'b1);
    end
    // nine bytes into an eight byte page wrap over the first byte written
    repeat (4) begin
      seed = xs(seed);
      @(posedge clk_sys_i);
      #1 sel = seed[2:0];
      repeat (4) @(posedge clk_sys_i);
      #1;
      wr(seed[15:8], 9, seed[23:16]);
      rd({seed[15:11], 3'h0}, 8);
    end
    @(posedge clk_sys_i);
    #1 wp = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    wr(seed[15:8], 1, ~seed[23:16]);
    rd({seed[15:11], 3'h0}, 8);
    close_out();
  end
endmodule : seeb_front_end_tb

`default_nettype wire
